// ---- tprm_pkg.sv ----
// package: register layout, field positions, codes and reset values for the timer pin route mux
package tprm_pkg;
    localparam int REG_W = 32;
    localparam int ADDR_W = 4;
    // byte offsets of the two route registers
    localparam logic [3:0] ROUTE_LOW_OFS = 4'h0;
    localparam logic [3:0] ROUTE_HIGH_OFS = 4'h4;
    localparam logic [31:0] ROUTE_LOW_RST = 32'h00000000;
    localparam logic [31:0] ROUTE_HIGH_RST = 32'h00000000;
    // writable bits; all others are reserved and read zero
    localparam logic [31:0] ROUTE_LOW_MASK = 32'h0000007C;
    localparam logic [31:0] ROUTE_HIGH_MASK = 32'h3F3C0000;
    localparam int CH0_IN_B_LSB = 4;
    localparam int CH0_OUT_A_LSB = 2;
    localparam int CH7_IN_B_LSB = 28;
    localparam int CH7_OUT_A_LSB = 26;
    localparam int CH7_IN_A_LSB = 24;
    localparam int CH6_IN_B_LSB = 20;
    localparam int CH6_OUT_A_LSB = 18;
    localparam logic [2:0] IN_B3_PIN1 = 3'h2;
    localparam logic [2:0] IN_B3_PIN2 = 3'h3;
    localparam logic [2:0] IN_B3_SUBCLK = 3'h6;
    localparam logic [2:0] IN_B3_TRIM = 3'h7;
    localparam logic [1:0] IN2_PIN1 = 2'h2;
    localparam logic [1:0] IN2_PIN2 = 2'h3;
    localparam logic [1:0] OUT_NONE = 2'h0;
    localparam logic [1:0] OUT_PIN0 = 2'h1;
    localparam logic [1:0] OUT_PIN1 = 2'h2;
    localparam logic [1:0] OUT_PIN2 = 2'h3;
    localparam int PINS = 3;
endpackage : tprm_pkg

// ---- tprm_if.sv ----
// interface: register port between software end and route mux end
`timescale 1ns/1ps
interface tprm_if;
    logic wr_en;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic dstby_rst;
    modport dev (input wr_en, input addr, input wdata, input dstby_rst, output rdata);
    modport sw (output wr_en, output addr, output wdata, output dstby_rst, input rdata);
endinterface : tprm_if

// ---- tprm_sel.sv ----
// module: one input select and optional output steer for a timer signal
`timescale 1ns/1ps
module tprm_sel (
    input wire logic [1:0] in_code, // input route code
    input wire logic [1:0] out_code, // output route code, 00 = none
    input wire logic [2:0] pin_in, // synchronised pin levels
    input wire logic tmr_out, // timer output level
    input wire logic odd_a, // odd channel a signal
    output logic tmr_in, // selected input
    output logic [2:0] pin_out, // pin drive levels
    output logic [2:0] pin_oe // pin output enables
);
    always_comb begin
        tmr_in = pin_in[0];
        pin_out = '0;
        pin_oe = '0;
        if (odd_a && out_code != tprm_pkg::OUT_NONE) begin
            tmr_in = 1'b0;
        end else if (in_code == tprm_pkg::IN2_PIN1) begin
            tmr_in = pin_in[1];
        end else if (in_code == tprm_pkg::IN2_PIN2) begin
            tmr_in = pin_in[2];
        end
        if (out_code == tprm_pkg::OUT_PIN0) begin
            pin_oe[0] = 1'b1;
            pin_out[0] = tmr_out;
        end else if (out_code == tprm_pkg::OUT_PIN1) begin
            pin_oe[1] = 1'b1;
            pin_out[1] = tmr_out;
        end else if (out_code == tprm_pkg::OUT_PIN2) begin
            pin_oe[2] = 1'b1;
            pin_out[2] = tmr_out;
        end
    end
endmodule : tprm_sel

// ---- tprm_dev.sv ----
// module: route mux device end, registers and pin routing
`timescale 1ns/1ps
module tprm_dev (
    input wire logic clock, // 40 MHz system clock
    input wire logic rst_b, // async reset, active low
    tprm_if.dev bus, // register port
    input wire logic [2:0] ch0_b_pin, // ch0 b pin choices
    input wire logic [2:0] ch6_b_pin, // ch6 b pin choices
    input wire logic [2:0] ch7_b_pin, // ch7 b pin choices
    input wire logic [2:0] ch7_a_pin, // ch7 a pin choices
    input wire logic sub_clock_output, // sub clock source
    input wire logic trim_clock, // divided fast oscillator clock
    input wire logic ch0_a_tmr, // ch0 timer a output
    input wire logic ch6_a_tmr, // ch6 timer a output
    input wire logic ch7_a_tmr, // ch7 timer a output
    output logic ch0_b_tmr_ff, // ch0 timer b input
    output logic ch6_b_tmr_ff, // ch6 timer b input
    output logic ch7_b_tmr_ff, // ch7 timer b input
    output logic ch7_a_tmr_ff, // ch7 timer a input
    output logic [2:0] ch0_a_pin_ff, // ch0 a pin levels
    output logic [2:0] ch0_a_oe_ff, // ch0 a pin enables
    output logic [2:0] ch6_a_pin_ff, // ch6 a pin levels
    output logic [2:0] ch6_a_oe_ff, // ch6 a pin enables
    output logic [2:0] ch7_a_pin_ff, // ch7 a pin levels
    output logic [2:0] ch7_a_oe_ff // ch7 a pin enables
);
    // ==========================================
    // registers
    logic [31:0] route_reg_low_ff;
    logic [31:0] route_reg_high_ff;
    logic [31:0] rdata_ff;
    // deep standby reset is ignored here on purpose: only rst_b clears the routes
    // writes to unmapped offsets match neither block and change nothing
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            route_reg_low_ff <= tprm_pkg::ROUTE_LOW_RST;
        end else if (bus.wr_en && bus.addr == tprm_pkg::ROUTE_LOW_OFS) begin
            route_reg_low_ff <= bus.wdata & tprm_pkg::ROUTE_LOW_MASK;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            route_reg_high_ff <= tprm_pkg::ROUTE_HIGH_RST;
        end else if (bus.wr_en && bus.addr == tprm_pkg::ROUTE_HIGH_OFS) begin
            route_reg_high_ff <= bus.wdata & tprm_pkg::ROUTE_HIGH_MASK;
        end
    end
    // ==========================================
    // read back
    // unmapped offsets read zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= '0;
        end else if (bus.addr == tprm_pkg::ROUTE_LOW_OFS) begin
            rdata_ff <= route_reg_low_ff;
        end else if (bus.addr == tprm_pkg::ROUTE_HIGH_OFS) begin
            rdata_ff <= route_reg_high_ff;
        end else begin
            rdata_ff <= '0;
        end
    end
    assign bus.rdata = rdata_ff;
    // ==========================================
    // pin synchronisers
    // trim clock is sampled like a pin, so its edges carry one cycle of jitter
    logic [13:0] raw_in;
    logic [13:0] sync1_ff;
    logic [13:0] sync2_ff;
    assign raw_in = {trim_clock, sub_clock_output, ch7_a_pin, ch7_b_pin, ch6_b_pin, ch0_b_pin};
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end
    // ==========================================
    // routing
    logic [2:0] b0_code;
    logic nxt_ch0_b;
    logic nxt_ch6_b;
    logic nxt_ch7_b;
    logic nxt_ch7_a;
    logic [2:0] a0_pin;
    logic [2:0] a0_oe;
    logic [2:0] a6_pin;
    logic [2:0] a6_oe;
    logic [2:0] a7_pin;
    logic [2:0] a7_oe;
    assign b0_code = route_reg_low_ff[tprm_pkg::CH0_IN_B_LSB +: 3];
    // ==========================================
    // ch0 b select, the only three bit code
    // 100 and 101 give a quiet low rather than a stale pin
    always_comb begin
        nxt_ch0_b = sync2_ff[0];
        if (b0_code == tprm_pkg::IN_B3_PIN1) begin
            nxt_ch0_b = sync2_ff[1];
        end else if (b0_code == tprm_pkg::IN_B3_PIN2) begin
            nxt_ch0_b = sync2_ff[2];
        end else if (b0_code == tprm_pkg::IN_B3_SUBCLK) begin
            nxt_ch0_b = sync2_ff[12];
        end else if (b0_code == tprm_pkg::IN_B3_TRIM) begin
            nxt_ch0_b = sync2_ff[13];
        end else if (b0_code[2]) begin
            nxt_ch0_b = 1'b0;
        end
    end
    // ==========================================
    // channel 0, 6 and 7 selectors
    // b signals are input only, so output codes are tied off
    tprm_sel u_b6 (.in_code(route_reg_high_ff[tprm_pkg::CH6_IN_B_LSB +: 2]), .out_code(tprm_pkg::OUT_NONE),
        .pin_in(sync2_ff[5:3]), .tmr_out(1'b0), .odd_a(1'b0), .tmr_in(nxt_ch6_b), .pin_out(), .pin_oe());
    tprm_sel u_b7 (.in_code(route_reg_high_ff[tprm_pkg::CH7_IN_B_LSB +: 2]), .out_code(tprm_pkg::OUT_NONE),
        .pin_in(sync2_ff[8:6]), .tmr_out(1'b0), .odd_a(1'b0), .tmr_in(nxt_ch7_b), .pin_out(), .pin_oe());
    // ch7 a owns both fields; an output route wins over the input field
    tprm_sel u_a7 (.in_code(route_reg_high_ff[tprm_pkg::CH7_IN_A_LSB +: 2]),
        .out_code(route_reg_high_ff[tprm_pkg::CH7_OUT_A_LSB +: 2]), .pin_in(sync2_ff[11:9]), .tmr_out(ch7_a_tmr),
        .odd_a(1'b1), .tmr_in(nxt_ch7_a), .pin_out(a7_pin), .pin_oe(a7_oe));
    // even a signals are output only: input side unused
    tprm_sel u_a0 (.in_code(2'h0), .out_code(route_reg_low_ff[tprm_pkg::CH0_OUT_A_LSB +: 2]), .pin_in(3'h0),
        .tmr_out(ch0_a_tmr), .odd_a(1'b0), .tmr_in(), .pin_out(a0_pin), .pin_oe(a0_oe));
    tprm_sel u_a6 (.in_code(2'h0), .out_code(route_reg_high_ff[tprm_pkg::CH6_OUT_A_LSB +: 2]), .pin_in(3'h0),
        .tmr_out(ch6_a_tmr), .odd_a(1'b0), .tmr_in(), .pin_out(a6_pin), .pin_oe(a6_oe));
    // ==========================================
    // timer input flops
    // pin levels pass through regardless of direction setting, except ch7 a, which reads low while its output route is set
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ch0_b_tmr_ff <= 1'b0;
        end else begin
            ch0_b_tmr_ff <= nxt_ch0_b;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ch6_b_tmr_ff <= 1'b0;
        end else begin
            ch6_b_tmr_ff <= nxt_ch6_b;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ch7_b_tmr_ff <= 1'b0;
        end else begin
            ch7_b_tmr_ff <= nxt_ch7_b;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ch7_a_tmr_ff <= 1'b0;
        end else begin
            ch7_a_tmr_ff <= nxt_ch7_a;
        end
    end
    // ==========================================
    // pin drive flops
    // enables follow the route field alone: the port direction setting has no say
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ch0_a_pin_ff <= '0;
            ch0_a_oe_ff <= '0;
        end else begin
            ch0_a_pin_ff <= a0_pin;
            ch0_a_oe_ff <= a0_oe;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ch6_a_pin_ff <= '0;
            ch6_a_oe_ff <= '0;
        end else begin
            ch6_a_pin_ff <= a6_pin;
            ch6_a_oe_ff <= a6_oe;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ch7_a_pin_ff <= '0;
            ch7_a_oe_ff <= '0;
        end else begin
            ch7_a_pin_ff <= a7_pin;
            ch7_a_oe_ff <= a7_oe;
        end
    end
endmodule : tprm_dev

// ---- tprm_sw.sv ----
// module: software end, issues register writes and reads
`timescale 1ns/1ps
module tprm_sw (
    input wire logic clock, // 40 MHz system clock
    input wire logic rst_b, // async reset, active low
    tprm_if.sw bus, // register port
    input wire logic req, // one-cycle request
    input wire logic req_wr, // 1 write, 0 read
    input wire logic [3:0] req_addr, // register offset
    input wire logic [31:0] req_data, // write data
    input wire logic dstby_req, // deep standby reset request
    output logic [31:0] rd_data_ff, // read result
    output logic rd_valid_ff // read result valid pulse
);
    logic wr_ff;
    logic [3:0] addr_ff;
    logic [31:0] data_ff;
    logic dst_ff;
    logic rd_pend_ff;
    logic rd_wait_ff;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ff <= 1'b0;
            addr_ff <= '0;
            data_ff <= '0;
            dst_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            rd_wait_ff <= 1'b0;
            rd_data_ff <= '0;
            rd_valid_ff <= 1'b0;
        end else begin
            wr_ff <= req && req_wr;
            dst_ff <= dstby_req;
            if (req) begin
                addr_ff <= req_addr;
                // reserved bits written as zero; any offset other than the low one takes the high mask
                data_ff <= req_addr == tprm_pkg::ROUTE_LOW_OFS ? req_data & tprm_pkg::ROUTE_LOW_MASK
                    : req_data & tprm_pkg::ROUTE_HIGH_MASK;
            end
            rd_pend_ff <= req && !req_wr;
            // read data leaves the device one edge after the address, so wait a second stage
            rd_wait_ff <= rd_pend_ff;
            rd_valid_ff <= rd_wait_ff;
            if (rd_wait_ff) begin
                rd_data_ff <= bus.rdata;
            end
        end
    end
    assign bus.wr_en = wr_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = data_ff;
    assign bus.dstby_rst = dst_ff;
endmodule : tprm_sw

// ---- tprm_properties.sv ----
// checker: register port properties of the timer pin route mux
`timescale 1ns/1ps
module tprm_properties (
    input wire logic clock, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic wr_en, // write strobe
    input wire logic [3:0] addr, // register offset
    input wire logic [31:0] wdata, // write data
    input wire logic [31:0] rdata, // read data
    input wire logic dstby_rst // deep standby reset
);
    // ==========
    // properties
    logic at_lo;
    logic at_hi;
    assign at_lo = addr == tprm_pkg::ROUTE_LOW_OFS;
    assign at_hi = addr == tprm_pkg::ROUTE_HIGH_OFS;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // rdata follows the address one edge later
    sequence wr_rd_lo;
        wr_en && at_lo ##1 !wr_en && at_lo;
    endsequence
    sequence wr_rd_hi;
        wr_en && at_hi ##1 !wr_en && at_hi;
    endsequence
    sequence standby_idle;
        !wr_en && dstby_rst ##1 !wr_en && dstby_rst && $stable(addr);
    endsequence
    a_low_bit7_zero: assert property (at_lo |=> !rdata[7]) else $error("low bit 7 read as one");
    a_low_bits10_zero: assert property (at_lo |=> rdata[1:0] == 2'h0) else $error("low bits 1:0 set");
    a_high_top_zero: assert property (at_hi |=> rdata[31:30] == 2'h0) else $error("high bits 31:30 set");
    a_high_mid_zero: assert property (at_hi |=> rdata[23:22] == 2'h0) else $error("high bits 23:22 set");
    a_high_gap_zero: assert property (at_hi |=> $countones(rdata[17:14]) == 0) else $error("high 17:14 set");
    a_low_readback: assert property (wr_rd_lo |=> rdata[6:2] == $past(wdata[6:2], 2))
        else $error("low route fields not stored");
    a_high_readback: assert property (wr_rd_hi |=> rdata[29:18] == $past(wdata[29:18], 2))
        else $error("high route fields not stored");
    a_standby_keep: assert property (standby_idle |=> $stable(rdata)) else $error("standby reset moved a route");
endmodule : tprm_properties

// ---- timer_pin_route_mux_tb.sv ----
// testbench: both ends of the timer pin route mux, register and routing checks
`timescale 1ns/1ps
module timer_pin_route_mux_tb;
    localparam logic [3:0] LO = tprm_pkg::ROUTE_LOW_OFS;
    localparam logic [3:0] HI = tprm_pkg::ROUTE_HIGH_OFS;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic req = 1'b0, req_wr = 1'b0, dstby_req = 1'b0, rd_valid_ff;
    logic [3:0] req_addr = 4'h0;
    logic [31:0] req_data = 32'h0, rd_data_ff, rnd = 32'h5812FCA6, wl, wh, lo_img, hi_img;
    logic sub_clk = 1'b0, trim_clk = 1'b0, a0 = 1'b0, a6 = 1'b0, a7 = 1'b0, b0, b6, b7, i7;
    logic [2:0] p0 = 3'h0, p6 = 3'h0, p7 = 3'h0, q7 = 3'h0, o0, e0, o6, e6, o7, e7;
    logic [31:0] exp_q[$];
    int err_count = 0, n_compared = 0;
    tprm_if bus ();
    always #12.5 clock = ~clock;
    // ==========
    // the two ends and the checker
    tprm_dev u_tprm_dev (.clock(clock), .rst_b(rst_b), .bus(bus), .ch0_b_pin(p0), .ch6_b_pin(p6), .ch7_b_pin(p7),
        .ch7_a_pin(q7), .sub_clock_output(sub_clk), .trim_clock(trim_clk), .ch0_a_tmr(a0), .ch6_a_tmr(a6),
        .ch7_a_tmr(a7), .ch0_b_tmr_ff(b0), .ch6_b_tmr_ff(b6), .ch7_b_tmr_ff(b7), .ch7_a_tmr_ff(i7),
        .ch0_a_pin_ff(o0), .ch0_a_oe_ff(e0), .ch6_a_pin_ff(o6), .ch6_a_oe_ff(e6), .ch7_a_pin_ff(o7), .ch7_a_oe_ff(e7));
    tprm_sw u_tprm_sw (.clock(clock), .rst_b(rst_b), .bus(bus), .req(req), .req_wr(req_wr), .req_addr(req_addr),
        .req_data(req_data), .dstby_req(dstby_req), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff));
    tprm_properties u_tprm_properties (.clock(clock), .rst_b(rst_b), .wr_en(bus.wr_en), .addr(bus.addr),
        .wdata(bus.wdata), .rdata(bus.rdata), .dstby_rst(bus.dstby_rst));
    // ==========
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic sel2(input logic [1:0] c, input logic [2:0] p);
        return c[1] ? p[{1'b0, c[0]} + 2'h1] : p[0];
    endfunction : sel2
    function automatic logic [2:0] oe(input logic [1:0] c);
        return (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
    endfunction : oe
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clock);
        req <= 1'b1;
        req_wr <= wr;
        req_addr <= a;
        req_data <= d;
        if (!wr) exp_q.push_back(e);
        @(posedge clock);
        req <= 1'b0;
    endtask : access
    task automatic drain();
        for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge clock);
        if (exp_q.size() != 0) chk("read answer count", 32'h0, 32'(exp_q.size()));
    endtask : drain
    // pin levels only matter where the enable is high
    task automatic routes();
        logic [2:0] c, m0, m6, m7;
        logic x0;
        repeat (6) @(posedge clock);
        c = lo_img[6:4];
        x0 = c[2] ? (c[1] & (c[0] ? trim_clk : sub_clk)) : sel2(c[1:0], p0);
        m0 = oe(lo_img[3:2]);
        m6 = oe(hi_img[19:18]);
        m7 = oe(hi_img[27:26]);
        chk("routes", 32'({x0, sel2(hi_img[21:20], p6), sel2(hi_img[29:28], p7),
            (hi_img[27:26] == 2'h0) & sel2(hi_img[25:24], q7), m0, m6, m7,
            m0 & {3{a0}}, m6 & {3{a6}}, m7 & {3{a7}}}),
            32'({b0, b6, b7, i7, e0, e6, e7, o0 & e0, o6 & e6, o7 & e7}));
    endtask : routes
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    always @(posedge clock) begin
        if (rd_valid_ff === 1'b1) begin
            if (exp_q.size() == 0) chk("unrequested read", 32'h0, 32'hFFFFFFFF);
            else chk("read data", exp_q.pop_front(), rd_data_ff);
        end
    end
    // ==========
    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        access(1'b0, LO, 32'h0, 32'h0);
        access(1'b0, HI, 32'h0, 32'h0);
        for (int i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            @(posedge clock);
            {p0, p6, p7, q7, sub_clk, trim_clk, a0, a6, a7} <= rnd[16:0];
            // reserved bits written with random values on purpose, they must come back zero
            wl = {rnd[31:7], i[2:0], i[4:3], rnd[1:0]};
            rnd = lfsr(rnd);
            wh = {rnd[3:0], i[3:0], rnd[31:8]};
            lo_img = wl & tprm_pkg::ROUTE_LOW_MASK;
            hi_img = wh & tprm_pkg::ROUTE_HIGH_MASK;
            access(1'b1, LO, wl, 32'h0);
            access(1'b1, HI, wh, 32'h0);
            access(1'b0, LO, 32'h0, lo_img);
            access(1'b0, HI, 32'h0, hi_img);
            routes();
        end
        access(1'b1, 4'h8, 32'hFFFFFFFF, 32'h0);
        access(1'b0, 4'h8, 32'h0, 32'h0);
        @(posedge clock);
        dstby_req <= 1'b1;
        repeat (4) @(posedge clock);
        access(1'b0, LO, 32'h0, lo_img);
        access(1'b0, HI, 32'h0, hi_img);
        routes();
        drain();
        @(posedge clock);
        dstby_req <= 1'b0;
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        lo_img = 32'h0;
        hi_img = 32'h0;
        access(1'b0, LO, 32'h0, 32'h0);
        access(1'b0, HI, 32'h0, 32'h0);
        routes();
        drain();
        wrap_up();
    end
endmodule : timer_pin_route_mux_tb
